// *** flash_reset_effects.v ***
// Purpose: reset-effect sequencing for a serial NOR flash
// Assumes: spiClk, csN, dataLineZero, hwResetN are async pins
// Notes:   transactions arrive already decoded as command bytes at csN rise
`timescale 1ns/10ps
`default_nettype none
`include "reset_effects_consts.vh"
module flash_reset_effects #(
  parameter RESET_CYCLES = `RESET_CYCLES
) (
  // Clock and reset
  input  wire                  ref_clk,
  input  wire                  rst,
  // Pins from host
  input  wire                  spiClk,
  input  wire                  csN,
  input  wire                  dataLineZero,
  input  wire                  hwResetN,
  // Decoded transaction at chip-select rise
  input  wire                  txnDone,
  input  wire [`REG_W-1:0]     txnCmd,
  // Embedded operation requests
  input  wire                  eraseStart,
  input  wire                  programStart,
  input  wire                  readStart,
  input  wire                  opDone,
  // Volatile writes
  input  wire                  volWrEn,
  input  wire [`NV_AW-1:0]     volWrIdx,
  input  wire [`REG_W-1:0]     volWrData,
  input  wire                  eccSet,
  input  wire [`REG_W-1:0]     eccSetData,
  // Non-volatile writes
  input  wire                  nvWrEn,
  input  wire [`NV_AW-1:0]     nvWrIdx,
  input  wire [`REG_W-1:0]     nvWrData,
  // Register views
  output reg  [`REG_W-1:0]     statusReg_r,
  output reg  [`REG_W-1:0]     configReg_r,
  output reg  [`REG_W-1:0]     protReg_r,
  output reg  [`REG_W-1:0]     ioMode_r,
  output reg  [`REG_W-1:0]     eccStatus_r,
  // Operation status
  output reg                   eraseAbort_r,
  output reg                   programAbort_r,
  output reg                   readAbort_r,
  output wire                  opBusy,
  // Output pins
  output wire                  readyBusyOut,
  output wire                  readyBusyOe,
  output wire                  outputsOe,
  output wire                  inputsEnable
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HOLD = 4'h2;
  localparam [3:0] S_LOAD = 4'h4;
  localparam [3:0] S_WAIT = 4'h8;
  localparam [1:0] K_POR  = 2'h0;
  localparam [1:0] K_HW   = 2'h1;
  localparam [1:0] K_SW   = 2'h2;
  localparam [2:0] OP_NONE = 3'h0;
  localparam [2:0] OP_ERASE = 3'h1;
  localparam [2:0] OP_PROG = 3'h2;
  localparam [2:0] OP_READ = 3'h4;

  // Two-flop synchronisers for pins
  reg [1:0] csSync_r;
  reg [1:0] dqSync_r;
  reg [1:0] rstPinSync_r;
  reg [1:0] sckSync_r;
  reg       csPrev_r;
  reg       sckPrev_r;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      csSync_r     <= 2'h3;
      dqSync_r     <= 2'h0;
      rstPinSync_r <= 2'h3;
      sckSync_r    <= 2'h0;
      csPrev_r     <= 1'b1;
      sckPrev_r    <= 1'b0;
    end else begin
      csSync_r     <= {csSync_r[0], csN};
      dqSync_r     <= {dqSync_r[0], dataLineZero};
      rstPinSync_r <= {rstPinSync_r[0], hwResetN};
      sckSync_r    <= {sckSync_r[0], spiClk};
      csPrev_r     <= csSync_r[1];
      sckPrev_r    <= sckSync_r[1];
    end
  end
  wire csFall = csPrev_r & ~csSync_r[1];
  wire csRise = ~csPrev_r & csSync_r[1];
  wire sckEdge = sckPrev_r ^ sckSync_r[1];

  reg [3:0]  state_r;
  reg [3:0]  state_nxt;
  reg [1:0]  kind_r;
  reg [31:0] cnt_r;
  reg [2:0]  loadIdx_r;
  reg [2:0]  op_r;
  reg        swArmed_r;
  reg [2:0]  sigCnt_r;
  reg        sigDq_r;
  reg        sigBad_r;
  reg        sckSeen_r;
  reg        hwPinPrev_r;

  // Wait count sized to the timer on purpose
  localparam [31:0] WAIT_LOAD = RESET_CYCLES - 1;

  // Pins shut only for power-on and hardware kinds
  function hw_quiet;
    input [3:0] st;
    input [1:0] kd;
    begin
      hw_quiet = (st != S_IDLE) && (kd != K_SW);
    end
  endfunction

  wire       inReset  = (state_r != S_IDLE);
  wire       hwKind   = (kind_r != K_SW);
  wire       hwQuiet  = hw_quiet(state_r, kind_r);
  wire [2:0] loadPrev = loadIdx_r - 3'h1;
  wire       loadLast = (loadIdx_r == `IDX_IOMODE + 3'h1);

  wire sigTrig = csRise & ~sigBad_r & ~sckSeen_r & (sigCnt_r == `SIG_PULSES - 3'h1) & ~inReset;
  wire hwPinFall = hwPinPrev_r & ~rstPinSync_r[1];
  wire swTrig = txnDone & ~inReset & swArmed_r & (txnCmd == `CMD_SW_RESET);
  wire hwTrig = (sigTrig | hwPinFall) & ~hwQuiet;

  wire [`REG_W-1:0] nvRd;
  wire [`NV_AW-1:0] rdIdx = loadIdx_r[`NV_AW-1:0];
  nv_store u_nv (
    .ref_clk (ref_clk),
    .wrEn    (nvWrEn & ~inReset),
    .wrAddr  (nvWrIdx),
    .wrData  (nvWrData),
    .rdAddr  (rdIdx),
    .rdData  (nvRd)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: begin
        if (hwTrig | swTrig) state_nxt = S_HOLD;
      end
      S_HOLD: state_nxt = S_LOAD;
      S_LOAD: begin
        if (loadLast) state_nxt = S_WAIT;
      end
      S_WAIT: begin
        if (cnt_r == 32'h0) state_nxt = S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    // Hardware pin reset restarts a running software reset; a signaling reset cannot, as it is gated off in reset
    if (hwTrig) begin
      state_nxt = S_HOLD;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r        <= S_HOLD;
      kind_r         <= K_POR;
      cnt_r          <= 32'h0;
      loadIdx_r      <= 3'h0;
      op_r           <= OP_NONE;
      swArmed_r      <= 1'b0;
      sigCnt_r       <= 3'h0;
      sigDq_r        <= 1'b0;
      sigBad_r       <= 1'b0;
      sckSeen_r      <= 1'b0;
      hwPinPrev_r    <= 1'b1;
      statusReg_r    <= 8'h00;
      configReg_r    <= 8'h00;
      protReg_r      <= 8'h00;
      ioMode_r       <= 8'h00;
      eccStatus_r    <= 8'h00;
      eraseAbort_r   <= 1'b0;
      programAbort_r <= 1'b0;
      readAbort_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      hwPinPrev_r <= rstPinSync_r[1];
      // Hardware pin ignored while a hardware reset runs
      if (hwTrig | swTrig) begin
        kind_r    <= hwTrig ? K_HW : K_SW;
        loadIdx_r <= 3'h0;
        eraseAbort_r   <= (op_r == OP_ERASE);
        programAbort_r <= (op_r == OP_PROG);
        readAbort_r    <= hwTrig & (op_r == OP_READ);
        op_r <= OP_NONE;
        eccStatus_r <= `ECC_CLEAR;
        if (hwTrig) begin
          statusReg_r <= 8'h00;
          configReg_r <= 8'h00;
          protReg_r   <= 8'h00;
        end
      end else if (state_r == S_HOLD) begin
        eccStatus_r <= `ECC_CLEAR;
        loadIdx_r   <= 3'h1;
      end else if (state_r == S_LOAD) begin
        loadIdx_r <= loadIdx_r + 3'h1;
        // Read data lags address by one cycle
        case (loadPrev)
          `IDX_STATUS: statusReg_r <= nvRd;
          `IDX_CONFIG: configReg_r <= nvRd;
          `IDX_PROT:   protReg_r <= nvRd;
          `IDX_IOMODE: begin
            if (hwKind) ioMode_r <= nvRd;
          end
          default: ;
        endcase
        cnt_r <= WAIT_LOAD;
      end else if (state_r == S_WAIT) begin
        cnt_r <= (cnt_r == 32'h0) ? 32'h0 : cnt_r - 32'h1;
      end else begin
        if (eccSet) begin
          eccStatus_r <= eccSetData;
        end
        if (volWrEn) begin
          case (volWrIdx)
            `IDX_STATUS: statusReg_r <= volWrData;
            `IDX_CONFIG: configReg_r <= volWrData;
            `IDX_PROT:   protReg_r   <= volWrData;
            `IDX_IOMODE: ioMode_r    <= volWrData;
            default: ;
          endcase
        end
        if (opDone) begin
          op_r <= OP_NONE;
        end else if (op_r == OP_NONE) begin
          if (eraseStart) op_r <= OP_ERASE;
          else if (programStart) op_r <= OP_PROG;
          else if (readStart) op_r <= OP_READ;
        end
      end
      if (txnDone & ~inReset) begin
        swArmed_r <= (txnCmd == `CMD_RESET_EN);
      end else if (inReset) begin
        swArmed_r <= 1'b0;
      end
      if (sckEdge | hwQuiet) begin
        sigCnt_r  <= 3'h0;
        sigBad_r  <= 1'b0;
        sckSeen_r <= sckEdge;
      end else if (csFall) begin
        sigBad_r  <= sigBad_r | ((sigCnt_r != 3'h0) & (dqSync_r[1] == sigDq_r));
        sckSeen_r <= 1'b0;
      end else if (csRise) begin
        // Clocked select is a transaction, not a pulse
        if (sckSeen_r) begin
          sigCnt_r <= 3'h0;
          sigBad_r <= 1'b0;
        end else begin
          sigDq_r  <= dqSync_r[1];
          sigCnt_r <= sigTrig ? 3'h0 : sigCnt_r + 3'h1;
          if (sigCnt_r == 3'h0) begin
            sigBad_r <= dqSync_r[1];
          end
        end
      end
    end
  end

  assign opBusy = (op_r != OP_NONE);
  assign readyBusyOut = ~inReset;
  assign readyBusyOe  = 1'b1;
  assign outputsOe    = ~hwQuiet;
  assign inputsEnable = ~hwQuiet;
endmodule // flash_reset_effects
`default_nettype wire

// *** flash_reset_effects_asserts.sv ***
// Purpose: reset-effect checks
// Assumes: bound to the top module
// Notes: idle, ECC and abort checks
`timescale 1ns/10ps
`default_nettype none
`include "reset_effects_consts.vh"
module flash_reset_effects_asserts #(parameter RESET_CYCLES = 200) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst,
  // Watched ports
  input wire logic       txnDone,
  input wire logic [7:0] txnCmd,
  input wire logic       opBusy,
  input wire logic       readyBusyOut,
  input wire logic       outputsOe,
  input wire logic       inputsEnable,
  input wire logic [7:0] ioMode_r,
  input wire logic [7:0] eccStatus_r,
  input wire logic       eraseAbort_r,
  input wire logic       readAbort_r
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic enArm_r;
  // Enable counts only for the next transaction
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) enArm_r <= 1'b0;
    else if (txnDone) enArm_r <= (txnCmd == `CMD_RESET_EN);
  end
  sequence swReq;
    txnDone && txnCmd == `CMD_SW_RESET && readyBusyOut;
  endsequence
  sequence swHold;
    !readyBusyOut && outputsOe ##1 !readyBusyOut;
  endsequence
  AST_SW_GO: assert property (enArm_r ##0 swReq |=> !readyBusyOut)
    else $error("armed reset not started");
  AST_SW_NO: assert property (!enArm_r ##0 swReq |=> readyBusyOut)
    else $error("unarmed reset started");
  AST_QUIET: assert property (!inputsEnable |-> !outputsOe && !readyBusyOut)
    else $error("pins active in reset");
  AST_ECC: assert property ($rose(readyBusyOut) |-> eccStatus_r == 8'h00)
    else $error("ecc status kept");
  AST_IDLE: assert property ($rose(readyBusyOut) |-> !opBusy)
    else $error("operation survived reset");
  AST_SWIO: assert property (swHold |-> $stable(ioMode_r))
    else $error("io mode moved in soft reset");
  AST_EABT: assert property ($rose(eraseAbort_r) |-> !readyBusyOut)
    else $error("erase abort outside reset");
  AST_RABT: assert property ($rose(readAbort_r) |-> !outputsOe)
    else $error("read abort outside hard reset");
endmodule // flash_reset_effects_asserts
bind flash_reset_effects flash_reset_effects_asserts #(.RESET_CYCLES(RESET_CYCLES)) CHK (.ref_clk, .rst,
  .txnDone, .txnCmd, .opBusy, .readyBusyOut, .outputsOe, .inputsEnable, .ioMode_r, .eccStatus_r,
  .eraseAbort_r, .readAbort_r);
`default_nettype wire

// *** nv_store.v ***
// Purpose: small non-volatile register image with registered read
// Assumes: single clock, write and read ports independent
// Notes:   contents survive every reset kind
`timescale 1ns/10ps
`default_nettype none
`include "reset_effects_consts.vh"
module nv_store (
  // Clock
  input  wire                  ref_clk,
  // Write port
  input  wire                  wrEn,
  input  wire [`NV_AW-1:0]     wrAddr,
  input  wire [`REG_W-1:0]     wrData,
  // Read port
  input  wire [`NV_AW-1:0]     rdAddr,
  output reg  [`REG_W-1:0]     rdData
);
  reg [`REG_W-1:0] mem [0:`NV_DEPTH-1];
  integer i;
  initial begin
    for (i = 0; i < `NV_DEPTH; i = i + 1) begin
      mem[i] = `NV_VAL_RST;
    end
  end
  // No reset here: non-volatile image never reverts
  always @(posedge ref_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // nv_store
`default_nettype wire

// *** reset_effects_consts.vh ***
// Purpose: constants for the flash reset-effect block
// Assumes: 200 MHz ref_clk
// Notes:   timing counts are plain defaults
`ifndef RESET_EFFECTS_CONSTS_VH
`define RESET_EFFECTS_CONSTS_VH
`define REG_W            8
`define NV_DEPTH         8
`define NV_AW            3
`define IDX_STATUS       3'h0
`define IDX_CONFIG       3'h1
`define IDX_PROT         3'h2
`define IDX_IOMODE       3'h3
`define NV_VAL_RST       8'h00
`define ECC_CLEAR        8'h00
`define CMD_RESET_EN     8'h66
`define CMD_SW_RESET     8'h99
`define CLK_PERIOD_PS    5000
`define RESET_TIME_NS    1000
`define RESET_CYCLES     ((`RESET_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SIG_PULSES       3'h4
`endif

// *** spi_host_model.sv ***
// Purpose: host driving reset triggers
// Assumes: link clock period 160 ns
// Notes: link clock still outside frames
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic       ref_clk,
  // Pins and decoded transaction
  output var logic       spiClk,
  output var logic       csN,
  output var logic       dataLineZero,
  output var logic       hwResetN,
  output var logic       txnDone,
  output var logic [7:0] txnCmd
);
  initial begin
    {spiClk, dataLineZero, txnDone, csN, hwResetN} = 5'h03;
    txnCmd = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic txn(input logic [7:0] cmd);
    tick(1);
    csN <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      tick(16);
      spiClk <= ~spiClk;
    end
    tick(16);
    csN <= 1'b1;
    txnDone <= 1'b1;
    txnCmd <= cmd;
    tick(1);
    txnDone <= 1'b0;
    txnCmd <= ~cmd;
  endtask
  task automatic sig_reset();
    for (int i = 0; i < 4; i++) begin
      tick(1);
      csN <= 1'b0;
      dataLineZero <= i[0];
      tick(4);
      csN <= 1'b1;
      tick(4);
    end
  endtask
  task automatic hw_reset();
    tick(1);
    hwResetN <= 1'b0;
    tick(10);
    hwResetN <= 1'b1;
  endtask
endmodule // spi_host_model
`default_nettype wire

// *** tb_flash_reset_effects.sv ***
// Purpose: self-checking bench for reset effects
// Assumes: reset time shortened to 40 cycles
// Notes: one note per reset completion
`timescale 1ns/10ps
`default_nettype none
`include "reset_effects_consts.vh"
module tb_flash_reset_effects;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic rbPrev = 1'b0;
  logic spiClk, csN, dataLineZero, hwResetN, txnDone, eraseStart, programStart, readStart, opDone;
  logic volWrEn, eccSet, nvWrEn, eraseAbort_r, programAbort_r, readAbort_r;
  logic opBusy, readyBusyOut, readyBusyOe, outputsOe, inputsEnable;
  logic [2:0] volWrIdx, nvWrIdx;
  logic [7:0] txnCmd, volWrData, eccSetData, nvWrData, statusReg_r, configReg_r, protReg_r, ioMode_r, eccStatus_r;
  logic [42:0] notes[$];
  int mismatches = 0;
  int check_count = 0;
  int seed = 40374;
  always #2.5 ref_clk = ~ref_clk;
  flash_reset_effects #(.RESET_CYCLES(40)) DUT (.ref_clk, .rst, .spiClk, .csN, .dataLineZero, .hwResetN,
    .txnDone, .txnCmd, .eraseStart, .programStart, .readStart, .opDone, .volWrEn, .volWrIdx, .volWrData,
    .eccSet, .eccSetData, .nvWrEn, .nvWrIdx, .nvWrData, .statusReg_r, .configReg_r, .protReg_r, .ioMode_r,
    .eccStatus_r, .eraseAbort_r, .programAbort_r, .readAbort_r, .opBusy, .readyBusyOut, .readyBusyOe,
    .outputsOe, .inputsEnable);
  spi_host_model HOST (.ref_clk, .spiClk, .csN, .dataLineZero, .hwResetN, .txnDone, .txnCmd);
  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [42:0] seen, input logic [42:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_rb(input logic lvl);
    int n = 0;
    while (readyBusyOut !== lvl) begin
      @(posedge ref_clk);
      n++;
      if (n > 2000) begin
        mismatches++;
        wrap_up();
      end
    end
  endtask
  // Kind 0 hard, 1 soft, 2 signaling; op 0 erase, 1 program, 2 read
  task automatic run(input int kind, input int op);
    logic [7:0] n[4];
    for (int i = 0; i < 4; i++) begin
      n[i] = $random(seed);
      @(posedge ref_clk);
      nvWrEn <= 1'b1;
      nvWrIdx <= i[2:0];
      nvWrData <= n[i];
      @(posedge ref_clk);
      nvWrEn <= 1'b0;
      volWrEn <= 1'b1;
      volWrIdx <= i[2:0];
      volWrData <= ~n[i];
    end
    @(posedge ref_clk);
    volWrEn <= 1'b0;
    eccSet <= 1'b1;
    eccSetData <= $random(seed) | 8'h01;
    {readStart, programStart, eraseStart} <= 3'h1 << op;
    @(posedge ref_clk);
    eccSet <= 1'b0;
    {readStart, programStart, eraseStart} <= 3'h0;
    notes.push_back({n[0], n[1], n[2], kind == 1 ? ~n[3] : n[3], 8'h00, op == 0, op == 1, op == 2 && kind != 1});
    if (kind == 0) HOST.hw_reset();
    else if (kind == 2) HOST.sig_reset();
    else begin
      HOST.txn(`CMD_RESET_EN);
      HOST.txn(`CMD_SW_RESET);
    end
    wait_rb(1'b0);
    chk({readyBusyOe, outputsOe, inputsEnable}, kind == 1 ? 3'h7 : 3'h4);
    // Start while busy must be dropped
    eraseStart <= 1'b1;
    @(posedge ref_clk);
    eraseStart <= 1'b0;
    wait_rb(1'b1);
  endtask
  always @(posedge ref_clk) begin
    rbPrev <= readyBusyOut;
    if (rbPrev === 1'b0 && readyBusyOut === 1'b1) begin
      if (notes.size() == 0) chk(43'h0, 43'h1);
      else chk({statusReg_r, configReg_r, protReg_r, ioMode_r, eccStatus_r, eraseAbort_r, programAbort_r,
        readAbort_r}, notes.pop_front());
    end
  end
  initial begin
    {eraseStart, programStart, readStart, opDone, volWrEn, eccSet, nvWrEn} = 7'h00;
    {volWrIdx, nvWrIdx, volWrData, eccSetData, nvWrData} = 30'h0;
    notes.push_back(43'h0);
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    wait_rb(1'b1);
    run(0, 0);
    run(1, 1);
    run(2, 2);
    run(1, 2);
    // Stray transaction cancels the enable
    HOST.txn(`CMD_RESET_EN);
    HOST.txn(8'h05);
    HOST.txn(`CMD_SW_RESET);
    repeat (4) @(posedge ref_clk);
    chk(readyBusyOut, 1'b1);
    chk(43'(notes.size()), 43'h0);
    wrap_up();
  end
endmodule // tb_flash_reset_effects
`default_nettype wire
